// ### dv/dci_ctrl_model.sv
/* Safety controller model: AXI4-Lite master with write and read tasks.
   Assumes one clock; the slave may answer after any number of cycles. */
`timescale 1ns/10ps
module dci_ctrl_model
(
    input  logic        aclk,
    output logic [7:0]  s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  logic        s_axi_wready,
    input  logic [1:0]  s_axi_bresp,
    input  logic        s_axi_bvalid,
    output logic        s_axi_bready,
    output logic [7:0]  s_axi_araddr,
    output logic        s_axi_arvalid,
    input  logic        s_axi_arready,
    input  logic [31:0] s_axi_rdata,
    input  logic [1:0]  s_axi_rresp,
    input  logic        s_axi_rvalid,
    output logic        s_axi_rready
);
    logic [1:0] last_bresp;

    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end

    // Payload and valid held until their own ready edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        last_bresp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
endmodule // dci_ctrl_model

// ### dv/dual_channel_discrepancy_input_bench.sv
/* Self-checking bench of the discrepancy input block.
   Assumes the controller model in dci_ctrl_model and a 4-cycle tick. */
`timescale 1ns/10ps
module dual_channel_discrepancy_input_bench;
    import dci_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, led_fault, led_safe, irq;
    logic [23:0] din = '0, in_image, led_chan;
    int failures = 0, compares = 0;
    // Rows: pair config, pins, expected image (standard mode)
    logic [59:0] rows [4] = '{{12'h000, 24'h008008, 24'h008008},
        {12'h001, 24'h001001, 24'h000001}, {12'h001, 24'h000001, 24'h000000},
        {12'h013, 24'hFFFFFF, 24'hFECFFF}};

    always #2 aclk = ~aclk;
    dci_input_eval #(.TICK_CYCLES(4)) dci_input_eval_inst (.*);
    dci_ctrl_model dci_ctrl_model_inst (.*);

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic sd(input logic [23:0] v);
        @(posedge aclk);
        din <= v;
        cyc(6);
    endtask
    task automatic chk(input string n, input logic [31:0] e, s);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, logic [31:0] e);
        dci_ctrl_model_inst.rd(a, rv, rr);
        chk(n, e, rv);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        dci_ctrl_model_inst.wr(a, d);
    endtask
    task automatic stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        cyc(20);
        aresetn <= 1'h1;
        cyc(2);
        rchk("dtime", ADDR_DTIME, 32'h0000000A);
        rchk("imask", ADDR_IMASK, 32'h00000000);
        foreach (rows[i])
        begin
            wr(ADDR_PAIR, {20'h00000, rows[i][59:48]});
            sd(rows[i][47:24]);
            chk("image", rows[i][23:0], in_image);
            chk("leds", din, led_chan);
        end
        dci_ctrl_model_inst.rd(8'h40, rv, rr);
        chk("resp", RESP_SLVERR, rr);
        wr(8'h40, 32'h00000001);
        chk("bresp", RESP_SLVERR, dci_ctrl_model_inst.last_bresp);
        wr(ADDR_PAIR, 32'h00000001);
        chk("bresp", RESP_OKAY, dci_ctrl_model_inst.last_bresp);
        wr(ADDR_DTIME, 32'h00000003);
        wr(ADDR_IMASK, 32'h00000001);
        wr(ADDR_CTRL, 32'h00000001);
        cyc(2);
        chk("safe", 1, led_safe);
        wr(ADDR_DTIME, 32'h00000007);
        rchk("dtime", ADDR_DTIME, 32'h00000003);
        sd(24'h001001);
        sd(24'h000001);
        chk("hold", 1, in_image);
        chk("fault", 0, led_fault);
        cyc(20);
        chk("expired", 0, in_image);
        chk("fault", 1, led_fault);
        chk("irq", 1, irq);
        rchk("diag", ADDR_DIAG, 32'h80000100);
        rchk("istat", ADDR_ISTAT, 32'h00000001);
        cyc(2);
        chk("irq", 0, irq);
        wr(ADDR_ERR, 32'h00000001);
        sd(24'h001001);
        chk("latched", 0, in_image);
        wr(ADDR_ERR, 32'h00000001);
        cyc(4);
        chk("cleared", 1, in_image);
        chk("fault", 0, led_fault);
        wr(ADDR_CTRL, 32'h00000000);
        wr(ADDR_BEHAV, 32'h00000001);
        wr(ADDR_CTRL, 32'h00000001);
        sd(24'h000001);
        chk("zero", 0, in_image);
        sd(24'h001001);
        chk("agree", 1, in_image);
        rchk("err", ADDR_ERR, 32'h00000000);
        stop_test;
    end

    // Whole run is a few hundred cycles; a hundred times that means a hang
    initial
    begin
        cyc(20000);
        failures++;
        stop_test;
    end
endmodule // dual_channel_discrepancy_input_bench

// ### hdl/dci_input_eval.sv
/*
 * 24-channel fail-safe digital input evaluation with AXI4-Lite registers.
 * Assumes input pins are asynchronous levels and one 250 MHz clock;
 * the safety controller reads the input image over the register port.
 */
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps

//Contract
//- In safety mode, compare each dual-voted pair and check any mismatch.
//- Mismatch still present at timer expiry forces the pair's result to 0.
//- Timer expiry records a diagnostic entry naming the faulty channel.
//- While the timer runs, inputs count as valid and no error arises.
//- A setting selects last-valid or zero output during discrepancy.
//- Last-valid mode holds the pre-mismatch value until agree or error.
//- Zero mode reports 0 at once when a mismatch is seen.
//- Single or dual evaluation is chosen separately per channel pair.
//- Pair n with n+12; voted result only at image bit n.
//- Single evaluation reports each channel at its own image bit.
//- Configuration may change at run time only in standard mode.
//- Evaluate 24 input channels as two groups of twelve.
//- Group fault indicator lights whenever any error is present.
//- Safety-mode indicator shows when the unit is in safety mode.
//- One status indicator per channel follows its input state.
module dci_input_eval
    import dci_pkg::*;
#(
    parameter int TICK_CYCLES = DISC_TICK_CYC
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [NUM_CH-1:0] din,
    output logic [NUM_CH-1:0]      in_image,
    output logic [NUM_CH-1:0]      led_chan,
    output logic                   led_fault,
    output logic                   led_safe,
    output logic                   irq
);
    if (TICK_CYCLES < 1)
    begin : g_bad_tick
        $error("TICK_CYCLES must be at least 1");
    end

    logic [NUM_CH-1:0]   din_s;
    logic                safe_r;
    logic [NUM_PAIR-1:0] pair_r;
    logic [NUM_PAIR-1:0] behav_r;
    logic [DTIME_W-1:0]  dtime_r;
    logic [NUM_PAIR-1:0] imask_r;
    logic [NUM_PAIR-1:0] istat_r;
    logic [NUM_PAIR-1:0] istat_nxt;
    logic [4:0]          diag_ch_r;
    logic [7:0]          diag_cnt_r;
    logic                diag_valid_r;
    logic [31:0]         tick_cnt_r;
    logic                tick;
    logic [NUM_PAIR-1:0] vote;
    logic [NUM_PAIR-1:0] err;
    logic [NUM_PAIR-1:0] expire;
    logic [NUM_PAIR-1:0] ack;
    logic [NUM_CH-1:0]   image_nxt;

    logic              aw_hold_r;
    logic              w_hold_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              do_wr;
    logic [31:0]       wmask;
    logic [31:0]       wval;
    logic              rd_take;
    logic [31:0]       rd_mux;
    logic              rd_hit;
    logic              wr_hit;

    // ----------------------------------------------------------------
    // Input synchronisation and millisecond tick
    // ----------------------------------------------------------------
    dci_sync #(.WIDTH(NUM_CH)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d_in    (din),
        .q_out   (din_s)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn || tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    // ----------------------------------------------------------------
    // Per-pair evaluation
    // ----------------------------------------------------------------
    for (genvar n = 0; n < NUM_PAIR; n++)
    begin : g_pair
        dci_pair_vote u_pair (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .in_left  (din_s[n]),
            .in_right (din_s[n+PAIR_OFS]),
            .active   (safe_r && pair_r[n]),
            .zero_beh (behav_r[n]),
            .dtime    (dtime_r),
            .tick     (tick),
            .ack      (ack[n]),
            .vote     (vote[n]),
            .err      (err[n]),
            .expire   (expire[n])
        );

        always_comb
        begin
            if (pair_r[n])
            begin
                // Voted result only at the left bit
                image_nxt[n]          = vote[n];
                image_nxt[n+PAIR_OFS] = 1'b0;
            end
            else
            begin
                image_nxt[n]          = din_s[n];
                image_nxt[n+PAIR_OFS] = din_s[n+PAIR_OFS];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_image  <= '0;
            led_chan  <= '0;
            led_fault <= 1'b0;
        end
        else
        begin
            in_image  <= image_nxt;
            led_chan  <= din_s;
            led_fault <= |err;
        end
    end
    assign led_safe = safe_r;

    // ----------------------------------------------------------------
    // Diagnostic buffer: lowest faulty channel of latest expiry
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            diag_ch_r    <= '0;
            diag_cnt_r   <= '0;
            diag_valid_r <= 1'b0;
        end
        else if (|expire)
        begin
            diag_valid_r <= 1'b1;
            diag_cnt_r   <= diag_cnt_r + 8'h01;
            for (int i = NUM_PAIR - 1; i >= 0; i--)
                if (expire[i])
                    diag_ch_r <= 5'(i);
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, cleared by reading it
    // ----------------------------------------------------------------
    always_comb
    begin
        istat_nxt = istat_r;
        if (rd_take && s_axi_araddr == ADDR_ISTAT)
            istat_nxt = '0;
        // Event in the clearing cycle is kept
        istat_nxt = istat_nxt | expire;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            istat_r <= '0;
        else
            istat_r <= istat_nxt;
    end
    assign irq = |(istat_r & imask_r);

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready  = !w_hold_r;
    assign do_wr         = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            else if (do_wr)
                aw_hold_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            else if (do_wr)
                w_hold_r <= 1'b0;
        end
    end

    always_comb
    begin
        for (int b = 0; b < 4; b++)
            wmask[b*8 +: 8] = {8{wstrb_r[b]}};
        wval = wdata_r & wmask;
        case (awaddr_r)
            ADDR_CTRL, ADDR_PAIR, ADDR_BEHAV, ADDR_DTIME,
            ADDR_ERR, ADDR_IMASK: wr_hit = 1'b1;
            default:              wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_wr)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Acknowledge pulse for latched discrepancy errors
    assign ack = (do_wr && awaddr_r == ADDR_ERR) ?
                 wval[NUM_PAIR-1:0] : '0;

    // ----------------------------------------------------------------
    // Control and configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            safe_r  <= CTRL_SAFE_RST;
            imask_r <= IMASK_RST;
        end
        else if (do_wr)
        begin
            if (awaddr_r == ADDR_CTRL && wstrb_r[0])
                safe_r <= wdata_r[CTRL_SAFE_BIT];
            if (awaddr_r == ADDR_IMASK)
                imask_r <= (imask_r & ~wmask[NUM_PAIR-1:0])
                           | wval[NUM_PAIR-1:0];
        end
    end

    // Locked in safety mode so a running vote never sees a change
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pair_r  <= PAIR_RST;
            behav_r <= BEHAV_RST;
            dtime_r <= DTIME_RST;
        end
        else if (do_wr && !safe_r)
        begin
            if (awaddr_r == ADDR_PAIR)
                pair_r <= (pair_r & ~wmask[NUM_PAIR-1:0])
                          | wval[NUM_PAIR-1:0];
            if (awaddr_r == ADDR_BEHAV)
                behav_r <= (behav_r & ~wmask[NUM_PAIR-1:0])
                           | wval[NUM_PAIR-1:0];
            if (awaddr_r == ADDR_DTIME)
                dtime_r <= (dtime_r & ~wmask[DTIME_W-1:0])
                           | wval[DTIME_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take       = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        rd_mux = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ADDR_CTRL:  rd_mux[CTRL_SAFE_BIT]    = safe_r;
            ADDR_PAIR:  rd_mux[NUM_PAIR-1:0]     = pair_r;
            ADDR_BEHAV: rd_mux[NUM_PAIR-1:0]     = behav_r;
            ADDR_DTIME: rd_mux[DTIME_W-1:0]      = dtime_r;
            ADDR_IMAGE: rd_mux[NUM_CH-1:0]       = in_image;
            ADDR_ERR:   rd_mux[NUM_PAIR-1:0]     = err;
            ADDR_ISTAT: rd_mux[NUM_PAIR-1:0]     = istat_r;
            ADDR_IMASK: rd_mux[NUM_PAIR-1:0]     = imask_r;
            ADDR_DIAG:
            begin
                rd_mux[4:0]                      = diag_ch_r;
                rd_mux[DIAG_CNT_LSB +: 8]        = diag_cnt_r;
                rd_mux[DIAG_VALID_BIT]           = diag_valid_r;
            end
            default:    rd_hit                   = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    cfg_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        safe_r && !$past(!safe_r) ##0 do_wr |=> $stable(pair_r)
            && $stable(behav_r) && $stable(dtime_r))
        else $error("configuration changed in safety mode");
    dual_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pair_r[0] |=> in_image[PAIR_OFS] == 1'b0
            && in_image[0] == $past(vote[0]))
        else $error("voted bit not at left position");
    single_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !pair_r[3] |=> in_image[15] == $past(din_s[15]))
        else $error("single channel bit misplaced");
    fault_led_a: assert property (@(posedge aclk) disable iff (!aresetn)
        |expire ##1 1'b1 |=> led_fault)
        else $error("fault indicator not lit after error");
    diag_rec_a: assert property (@(posedge aclk) disable iff (!aresetn)
        |expire |=> diag_valid_r
            && (($past(expire) >> diag_ch_r) & 12'h001) == 12'h001
            && ($past(expire) & ((12'h001 << diag_ch_r) - 12'h001)) == '0
            && diag_cnt_r == $past(diag_cnt_r) + 8'h01)
        else $error("diagnostic entry not recorded");
    irq_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (expire & imask_r) != '0 |=> irq)
        else $error("unmasked event did not raise irq");
endmodule // dci_input_eval

// ### hdl/dci_pair_vote.sv
/*
 * Discrepancy check of one channel pair (left n, right n+12).
 * Assumes synchronised inputs and a one-cycle millisecond tick.
 */
`timescale 1ns/10ps
module dci_pair_vote
    import dci_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               in_left,
    input  wire logic               in_right,
    input  wire logic               active,
    input  wire logic               zero_beh,
    input  wire logic [DTIME_W-1:0] dtime,
    input  wire logic               tick,
    input  wire logic               ack,
    output logic                    vote,
    output logic                    err,
    output logic                    expire
);
    dci_pair_state_t    state_r;
    logic [DTIME_W-1:0] cnt_r;
    logic               last_r;
    logic               mism;
    logic               in_disc;

    assign mism    = in_left ^ in_right;
    assign err     = (state_r == PS_ERROR);
    assign in_disc = active && mism && (state_r != PS_ERROR);
    assign expire  = (state_r == PS_DISC) && in_disc && (cnt_r >= dtime);

    // ----------------------------------------------------------------
    // Pair state
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= PS_AGREE;
            cnt_r   <= '0;
        end
        else
        begin
            case (state_r)
                PS_AGREE:
                begin
                    cnt_r <= '0;
                    if (active && mism)
                        state_r <= PS_DISC;
                end
                PS_DISC:
                begin
                    if (!active || !mism)
                    begin
                        state_r <= PS_AGREE;
                        cnt_r   <= '0;
                    end
                    else if (expire)
                        state_r <= PS_ERROR;
                    else if (tick)
                        cnt_r <= cnt_r + 1'b1;
                end
                PS_ERROR:
                begin
                    // Ack during expiry cycle is lost: set wins
                    if (!mism && ack)
                        state_r <= PS_AGREE;
                end
                default: state_r <= PS_AGREE;
            endcase
        end
    end

    // Last value seen in PS_AGREE while both readings agreed
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            last_r <= 1'b0;
        else if (state_r == PS_AGREE && !mism)
            last_r <= in_left;
    end

    always_comb
    begin
        if (err)
            vote = 1'b0;
        else if (in_disc)
            vote = zero_beh ? 1'b0 : last_r;
        else
            vote = in_left & in_right;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence agree_then_split;
        (active && !mism && state_r == PS_AGREE)
        ##1 (active && mism && !zero_beh);
    endsequence

    start_timer_a: assert property (
        state_r == PS_AGREE && active && mism |=> state_r == PS_DISC)
        else $error("timer not started on mismatch");
    clear_timer_a: assert property (
        state_r == PS_DISC && !mism |=> state_r == PS_AGREE && cnt_r == 0)
        else $error("timer not cleared on agreement");
    hold_last_a: assert property (
        agree_then_split |-> vote == $past(in_left))
        else $error("last valid value not held");
    zero_report_a: assert property (
        active && mism && zero_beh |-> !vote)
        else $error("zero behaviour reported one");
    no_early_err_a: assert property (
        state_r == PS_DISC && cnt_r < dtime && mism && active |=> !err)
        else $error("error before discrepancy time");
    expiry_err_a: assert property (
        expire |=> err && !vote)
        else $error("expiry did not force zero");
    err_latch_a: assert property (
        err && (mism || !ack) |=> err && !vote)
        else $error("error released without ack");
endmodule // dci_pair_vote

// ### hdl/dci_pkg.sv
/*
 * Shared constants and types of the dual-channel discrepancy input block.
 * Assumes a single 250 MHz clock and an AXI4-Lite register port.
 */
package dci_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int NUM_CH   = 24;
    localparam int NUM_PAIR = 12;
    localparam int PAIR_OFS = 12;
    localparam int DTIME_W  = 16;
    localparam int ADDR_W   = 8;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PAIR  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_BEHAV = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_DTIME = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IMAGE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_ERR   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_ISTAT = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_IMASK = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_DIAG  = 8'h20;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_SAFE_BIT  = 0;
    localparam int DIAG_CNT_LSB   = 8;
    localparam int DIAG_VALID_BIT = 31;
    localparam logic                CTRL_SAFE_RST = 1'b0;
    localparam logic [NUM_PAIR-1:0] PAIR_RST      = 12'h000;
    localparam logic [NUM_PAIR-1:0] BEHAV_RST     = 12'h000;
    localparam logic [DTIME_W-1:0]  DTIME_RST     = 16'h000A;
    localparam logic [NUM_PAIR-1:0] IMASK_RST     = 12'h000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Timing: discrepancy time counts in 1 ms ticks
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int DISC_TICK_NS  = 1000000;
    localparam int DISC_TICK_CYC = DISC_TICK_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PS_AGREE,
        PS_DISC,
        PS_ERROR
    } dci_pair_state_t;

endpackage

// ### hdl/dci_sync.sv
/*
 * Two-flop synchroniser for a bus of independent level inputs.
 * Assumes each bit is a slow level; no word coherence is promised.
 */
`timescale 1ns/10ps
module dci_sync
#(
    parameter int WIDTH = 24
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            q_out  <= '0;
        end
        else
        begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule // dci_sync
